// ---- include/ucr_pkg.sv ----
// Constants and field layouts of the UART channel register bank.
package ucr_pkg;
    // Register offsets selected by the four low address bits.
    localparam logic [3:0] UCR_OFF_DATA   = 4'h0;
    localparam logic [3:0] UCR_OFF_IER    = 4'h1;
    localparam logic [3:0] UCR_OFF_ISR    = 4'h2;
    localparam logic [3:0] UCR_OFF_LCR    = 4'h3;
    localparam logic [3:0] UCR_OFF_MCR    = 4'h4;
    localparam logic [3:0] UCR_OFF_LSR    = 4'h5;
    localparam logic [3:0] UCR_OFF_MSR    = 4'h6;
    localparam logic [3:0] UCR_OFF_SPR    = 4'h7;
    localparam logic [3:0] UCR_OFF_FEAT   = 4'h8;
    localparam logic [3:0] UCR_OFF_EFR    = 4'h9;
    localparam logic [3:0] UCR_OFF_TXLVL  = 4'ha;
    localparam logic [3:0] UCR_OFF_RXLVL  = 4'hb;
    localparam logic [3:0] UCR_OFF_XCHAR  = 4'hc;
    localparam logic [3:0] UCR_OFF_STOP2  = 4'hd;
    localparam logic [3:0] UCR_OFF_RES1   = 4'he;
    localparam logic [3:0] UCR_OFF_RES2   = 4'hf;
    // Bit positions.
    localparam int UCR_DLAB_BIT    = 7;
    localparam int UCR_EFR_EN_BIT  = 4;
    localparam int UCR_LOOP_BIT    = 4;
    localparam int UCR_GP1_BIT     = 2;
    localparam int UCR_GP2_BIT     = 3;
    localparam int UCR_FIFO_EN_BIT = 0;
    localparam int UCR_RXRST_BIT   = 1;
    localparam int UCR_TXRST_BIT   = 2;
    localparam int UCR_RESUME_BIT  = 1;
    localparam int UCR_STOP_BIT    = 0;
    localparam int UCR_DLY_LSB     = 4;
    localparam int UCR_DLY_W       = 4;
    // Masks of the bits unlocked by the enhanced-function enable, plus the reserved interrupt-enable bit and the FIFO bits of ISR.
    localparam logic [7:0] UCR_IER_GATED = 8'he0;
    localparam logic [7:0] UCR_IER_RSVD  = 8'h10;
    localparam logic [7:0] UCR_ISR_GATED = 8'h30;
    localparam logic [7:0] UCR_FCR_GATED = 8'h30;
    localparam logic [7:0] UCR_MCR_GATED = 8'he4;
    localparam logic [7:0] UCR_ISR_FIFO  = 8'hc0;
    // Reset values.
    localparam logic [7:0]  UCR_RST_BYTE = 8'h00;
    localparam logic [15:0] UCR_RST_DIV  = 16'h0000;
    localparam logic [15:0] UCR_CNT_ONE  = 16'h0001;
endpackage

// ---- hdl/ucr_regs.sv ----
// Register bank of one UART channel, with its divisor and baud generator.
// How it works
// - Sixteen-bit baud counter times transmitter and receiver.
// - Divisor bytes reachable only with divisor-enable set.
// - Offset A: read tx level, write tx trigger.
// - Offset B: read rx level, write rx trigger.
// - Offset C: write stop char, read-clear flags.
// - Offset D loads second stop character.
// - Offset E loads first resume character.
// - Offset F loads second resume character.
// - Enhanced enable unlocks the gated extra bits.
// - Interrupt enable bits fixed; bit four zero.
// - General-purpose outputs seen only in loopback.
// - Offset zero: holding bytes or divisor low.
// - Four address bits select sixteen registers.
// - Modem-status offset write loads turn-around delay while enhanced enable is set.
module ucr_regs #(
    parameter int DIV_W = 16
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_resetn,
    input  wire logic [3:0]       i_addr,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    input  wire logic [7:0]       i_wdata,
    output logic      [7:0]       o_rdata,
    input  wire logic [7:0]       i_rx_data,
    input  wire logic [7:0]       i_tx_level,
    input  wire logic [7:0]       i_rx_level,
    input  wire logic [5:0]       i_int_status,
    input  wire logic [7:0]       i_line_status,
    input  wire logic [7:0]       i_modem_status,
    input  wire logic             i_stop_det,
    input  wire logic             i_resume_det,
    output logic                  o_rx_pop,
    output logic                  o_tx_push,
    output logic      [7:0]       o_tx_data,
    output logic                  o_isr_read,
    output logic                  o_lsr_read,
    output logic                  o_msr_read,
    output logic                  o_rx_fifo_reset,
    output logic                  o_tx_fifo_reset,
    output logic                  o_baud_tick,
    output logic      [DIV_W-1:0] o_divisor,
    output logic      [7:0]       o_int_enable,
    output logic      [7:0]       o_fifo_control,
    output logic      [7:0]       o_line_control,
    output logic      [7:0]       o_modem_control,
    output logic      [1:0]       o_gp_output_loop,
    output logic      [7:0]       o_feature_control,
    output logic      [7:0]       o_enh_function,
    output logic      [7:0]       o_tx_trigger,
    output logic      [7:0]       o_rx_trigger,
    output logic      [7:0]       o_stop_char_1,
    output logic      [7:0]       o_stop_char_2,
    output logic      [7:0]       o_resume_char_1,
    output logic      [7:0]       o_resume_char_2,
    output logic      [3:0]       o_turnaround_delay,
    output logic      [1:0]       o_flow_flags
);
    import ucr_pkg::*;

    logic [DIV_W-1:0] divisor_r;
    logic [DIV_W-1:0] baud_cnt_r;
    logic [7:0]       ier_r;
    logic [7:0]       fcr_r;
    logic [7:0]       lcr_r;
    logic [7:0]       mcr_r;
    logic [7:0]       spr_r;
    logic [7:0]       feat_r;
    logic [7:0]       efr_r;
    logic [7:0]       tx_fifo_trigger_r;
    logic [7:0]       rx_fifo_trigger_r;
    logic [7:0]       stop1_r;
    logic [7:0]       stop2_r;
    logic [7:0]       res1_r;
    logic [7:0]       res2_r;
    logic [3:0]       dly_r;
    logic [1:0]       flags_r;
    logic [1:0]       flags_nxt;
    logic [7:0]       rdata_nxt;
    logic             dlab;
    logic             enh;
    logic             tick_nxt;

    // Clears bits that are gated off while the enhanced enable is low.
    function automatic logic [7:0] gate(input logic [7:0] v, input logic [7:0] m, input logic en);
        gate = en ? v : (v & ~m);
    endfunction

    // Read or write strobe for one offset of the sixteen.
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off, input logic s);
        hit = s && (a == off);
    endfunction

    assign dlab = lcr_r[UCR_DLAB_BIT];
    assign enh  = efr_r[UCR_EFR_EN_BIT];

    // Divisor bytes load only while divisor-enable is set.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            divisor_r <= UCR_RST_DIV;
        end else if (dlab) begin
            if (hit(i_addr, UCR_OFF_DATA, i_wr)) begin
                divisor_r[7:0] <= i_wdata;
            end
            if (hit(i_addr, UCR_OFF_IER, i_wr)) begin
                divisor_r[DIV_W-1:8] <= i_wdata[DIV_W-9:0];
            end
        end
    end

    // Legacy control registers; gated bits are dropped on write.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ier_r <= UCR_RST_BYTE;
            fcr_r <= UCR_RST_BYTE;
            lcr_r <= UCR_RST_BYTE;
            mcr_r <= UCR_RST_BYTE;
            spr_r <= UCR_RST_BYTE;
        end else begin
            if (hit(i_addr, UCR_OFF_IER, i_wr) && !dlab) begin
                ier_r <= gate(i_wdata, UCR_IER_GATED, enh) & ~UCR_IER_RSVD;
            end
            if (hit(i_addr, UCR_OFF_ISR, i_wr)) begin
                fcr_r <= gate(i_wdata, UCR_FCR_GATED, enh);
            end
            if (hit(i_addr, UCR_OFF_LCR, i_wr)) begin
                lcr_r <= i_wdata;
            end
            if (hit(i_addr, UCR_OFF_MCR, i_wr)) begin
                mcr_r <= gate(i_wdata, UCR_MCR_GATED, enh);
            end
            if (hit(i_addr, UCR_OFF_SPR, i_wr)) begin
                spr_r <= i_wdata;
            end
        end
    end

    // Enhanced registers in the upper eight offsets.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            feat_r  <= UCR_RST_BYTE;
            efr_r   <= UCR_RST_BYTE;
            tx_fifo_trigger_r <= UCR_RST_BYTE;
            rx_fifo_trigger_r <= UCR_RST_BYTE;
            stop1_r <= UCR_RST_BYTE;
            stop2_r <= UCR_RST_BYTE;
            res1_r  <= UCR_RST_BYTE;
            res2_r  <= UCR_RST_BYTE;
        end else begin
            if (hit(i_addr, UCR_OFF_FEAT, i_wr)) begin
                feat_r <= i_wdata;
            end
            if (hit(i_addr, UCR_OFF_EFR, i_wr)) begin
                efr_r <= i_wdata;
            end
            if (hit(i_addr, UCR_OFF_TXLVL, i_wr)) begin
                tx_fifo_trigger_r <= i_wdata;
            end
            if (hit(i_addr, UCR_OFF_RXLVL, i_wr)) begin
                rx_fifo_trigger_r <= i_wdata;
            end
            if (hit(i_addr, UCR_OFF_XCHAR, i_wr)) begin
                stop1_r <= i_wdata;
            end
            if (hit(i_addr, UCR_OFF_STOP2, i_wr)) begin
                stop2_r <= i_wdata;
            end
            if (hit(i_addr, UCR_OFF_RES1, i_wr)) begin
                res1_r <= i_wdata;
            end
            if (hit(i_addr, UCR_OFF_RES2, i_wr)) begin
                res2_r <= i_wdata;
            end
        end
    end

    // Turn-around delay shares the status offset, write direction only.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            dly_r <= UCR_RST_BYTE[3:0];
        end else if (hit(i_addr, UCR_OFF_MSR, i_wr) && enh) begin
            dly_r <= i_wdata[UCR_DLY_LSB +: UCR_DLY_W];
        end
    end

    // Detection flags: a new detection wins over the clearing read.
    always_comb begin
        flags_nxt = flags_r;
        if (hit(i_addr, UCR_OFF_XCHAR, i_rd)) begin
            flags_nxt = 2'h0;
        end
        if (i_stop_det) begin
            flags_nxt[UCR_STOP_BIT] = 1'b1;
        end
        if (i_resume_det) begin
            flags_nxt[UCR_RESUME_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            flags_r <= 2'h0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Read multiplexer; direction splits shared offsets.
    always_comb begin
        rdata_nxt = UCR_RST_BYTE;
        case (i_addr)
            UCR_OFF_DATA:  rdata_nxt = dlab ? divisor_r[7:0] : i_rx_data;
            UCR_OFF_IER:   rdata_nxt = dlab ? divisor_r[DIV_W-1:8] : o_int_enable;
            UCR_OFF_ISR:   rdata_nxt = gate({fcr_r[UCR_FIFO_EN_BIT], fcr_r[UCR_FIFO_EN_BIT], i_int_status},
                                            UCR_ISR_GATED, enh);
            UCR_OFF_LCR:   rdata_nxt = lcr_r;
            UCR_OFF_MCR:   rdata_nxt = mcr_r;
            UCR_OFF_LSR:   rdata_nxt = i_line_status;
            UCR_OFF_MSR:   rdata_nxt = i_modem_status;
            UCR_OFF_SPR:   rdata_nxt = spr_r;
            UCR_OFF_FEAT:  rdata_nxt = feat_r;
            UCR_OFF_EFR:   rdata_nxt = efr_r;
            UCR_OFF_TXLVL: rdata_nxt = i_tx_level;
            UCR_OFF_RXLVL: rdata_nxt = i_rx_level;
            UCR_OFF_XCHAR: rdata_nxt = {6'h00, flags_r};
            default:       rdata_nxt = UCR_RST_BYTE;
        endcase
    end

    // Read data and read side-effect strobes, registered.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata    <= UCR_RST_BYTE;
            o_rx_pop   <= 1'b0;
            o_isr_read <= 1'b0;
            o_lsr_read <= 1'b0;
            o_msr_read <= 1'b0;
        end else begin
            if (i_rd) begin
                o_rdata <= rdata_nxt;
            end
            o_rx_pop   <= hit(i_addr, UCR_OFF_DATA, i_rd) && !dlab;
            o_isr_read <= hit(i_addr, UCR_OFF_ISR, i_rd);
            o_lsr_read <= hit(i_addr, UCR_OFF_LSR, i_rd);
            o_msr_read <= hit(i_addr, UCR_OFF_MSR, i_rd);
        end
    end

    // Write side-effect strobes: transmit push and FIFO resets.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_push       <= 1'b0;
            o_tx_data       <= UCR_RST_BYTE;
            o_rx_fifo_reset <= 1'b0;
            o_tx_fifo_reset <= 1'b0;
        end else begin
            o_tx_push       <= hit(i_addr, UCR_OFF_DATA, i_wr) && !dlab;
            o_rx_fifo_reset <= hit(i_addr, UCR_OFF_ISR, i_wr) && i_wdata[UCR_RXRST_BIT];
            o_tx_fifo_reset <= hit(i_addr, UCR_OFF_ISR, i_wr) && i_wdata[UCR_TXRST_BIT];
            if (hit(i_addr, UCR_OFF_DATA, i_wr) && !dlab) begin
                o_tx_data <= i_wdata;
            end
        end
    end

    // Baud generator: reloads from the divisor, ticks once per period.
    assign tick_nxt = (divisor_r != UCR_RST_DIV) && (baud_cnt_r == UCR_CNT_ONE);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            baud_cnt_r  <= UCR_RST_DIV;
            o_baud_tick <= 1'b0;
        end else begin
            o_baud_tick <= tick_nxt;
            if (divisor_r == UCR_RST_DIV) begin
                baud_cnt_r <= UCR_RST_DIV;
            end else if (baud_cnt_r <= UCR_CNT_ONE) begin
                baud_cnt_r <= divisor_r;
            end else begin
                baud_cnt_r <= baud_cnt_r - UCR_CNT_ONE;
            end
        end
    end

    // Channel-facing views; gated bits are forced low when locked.
    assign o_divisor          = divisor_r;
    assign o_int_enable       = gate(ier_r, UCR_IER_GATED, enh) & ~UCR_IER_RSVD;
    assign o_fifo_control     = gate(fcr_r, UCR_FCR_GATED, enh);
    assign o_line_control     = lcr_r;
    assign o_modem_control    = gate(mcr_r, UCR_MCR_GATED, enh);
    assign o_gp_output_loop   = mcr_r[UCR_LOOP_BIT] ? {mcr_r[UCR_GP2_BIT], mcr_r[UCR_GP1_BIT] & enh} : 2'h0;
    assign o_feature_control  = feat_r;
    assign o_enh_function     = efr_r;
    assign o_tx_trigger       = tx_fifo_trigger_r;
    assign o_rx_trigger       = rx_fifo_trigger_r;
    assign o_stop_char_1      = stop1_r;
    assign o_stop_char_2      = stop2_r;
    assign o_resume_char_1    = res1_r;
    assign o_resume_char_2    = res2_r;
    assign o_turnaround_delay = dly_r;
    assign o_flow_flags       = flags_r;

    // Checks on the register bank.
    property p_div_low;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && i_addr == UCR_OFF_DATA && dlab) |=> (o_divisor[7:0] == $past(i_wdata)) && !o_tx_push;
    endproperty
    a_div_low: assert property (p_div_low) else $error("divisor low not loaded");

    property p_div_locked;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && i_addr == UCR_OFF_IER && !dlab) |=> $stable(o_divisor);
    endproperty
    a_div_locked: assert property (p_div_locked) else $error("divisor changed while locked");

    property p_tx_push;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && i_addr == UCR_OFF_DATA && !dlab) |=> o_tx_push && (o_tx_data == $past(i_wdata)) ##1 !o_tx_push;
    endproperty
    a_tx_push: assert property (p_tx_push) else $error("transmit byte not pushed once");

    property p_tx_level;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_rd && i_addr == UCR_OFF_TXLVL) |=> o_rdata == $past(i_tx_level);
    endproperty
    a_tx_level: assert property (p_tx_level) else $error("tx level read wrong");

    property p_rx_trig;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && i_addr == UCR_OFF_RXLVL) |=> o_rx_trigger == $past(i_wdata);
    endproperty
    a_rx_trig: assert property (p_rx_trig) else $error("rx trigger not loaded");

    property p_flag_clear;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_rd && i_addr == UCR_OFF_XCHAR && !i_stop_det && !i_resume_det)
        |=> (o_flow_flags == 2'h0) && (o_rdata[7:2] == 6'h00);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared by read");

    property p_flag_set;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        i_stop_det |=> o_flow_flags[UCR_STOP_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("stop detection lost");

    property p_res2;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && i_addr == UCR_OFF_RES2) |=> o_resume_char_2 == $past(i_wdata);
    endproperty
    a_res2: assert property (p_res2) else $error("resume char two not loaded");

    property p_gated;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !enh |-> (o_int_enable[7:4] == 4'h0) && (o_modem_control[7:5] == 3'h0);
    endproperty
    a_gated: assert property (p_gated) else $error("gated bits active while locked");

    property p_gp_loop;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !o_modem_control[UCR_LOOP_BIT] |-> o_gp_output_loop == 2'h0;
    endproperty
    a_gp_loop: assert property (p_gp_loop) else $error("gp output outside loopback");

    property p_baud;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_baud_tick |-> ($past(baud_cnt_r) == UCR_CNT_ONE) && ($past(divisor_r) != UCR_RST_DIV);
    endproperty
    a_baud: assert property (p_baud) else $error("baud tick at wrong count");

    property p_delay;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && i_addr == UCR_OFF_MSR && enh) |=> o_turnaround_delay == $past(i_wdata[7:4]);
    endproperty
    a_delay: assert property (p_delay) else $error("delay not loaded");

    c_div_prog: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && i_addr == UCR_OFF_DATA && dlab) ##[1:20] o_baud_tick);
    c_flag_race: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_rd && i_addr == UCR_OFF_XCHAR && i_resume_det);
    c_rx_pop: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_rx_pop);
endmodule

// ---- tb/ucr_host_model.sv ----
// Host bus master model that issues register reads and writes to one channel.
module ucr_host_model (
    input  wire logic       i_clk_sys,
    output logic      [3:0] o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import ucr_pkg::*;
    logic [11:0] exp_q[$];
    // The bus is idle from time zero.
    initial begin
        o_addr  = 4'h0;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 8'h00;
    end
    // One write, taken at the next rising edge.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        o_rd    <= 1'b0;
    endtask
    // One read; the expected byte is noted with its offset for the watcher.
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_wr   <= 1'b0;
        o_rd   <= 1'b1;
        exp_q.push_back({a, e});
    endtask
    // Drops the strobes and returns once the last access has landed.
    task automatic idle();
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        @(posedge i_clk_sys);
        #1;
    endtask
    // Divisor-enable is set before either divisor byte, and cleared after.
    task automatic set_div(input logic [15:0] dv);
        wr(UCR_OFF_LCR, 8'h80);
        wr(UCR_OFF_DATA, dv[7:0]);
        wr(UCR_OFF_IER, dv[15:8]);
        wr(UCR_OFF_LCR, 8'h00);
    endtask
endmodule

// ---- tb/ucr_regs_tb.sv ----
// Self-checking testbench of the UART channel register bank.
module ucr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ucr_pkg::*;
    logic        clk_sys, resetn, wr, rd, stop_det, resume_det, tx_push, tick, rd_seen;
    logic [3:0]  addr, dly;
    logic [7:0]  wdata, rdata, rx_data, tx_lvl, rx_lvl, ls, ms, tx_data, int_enable, fifo_control, txt, rxt;
    logic [7:0]  st1, st2, rs1, rs2, d;
    logic [5:0]  ist;
    logic [1:0]  gp;
    logic        pop, rx_rst, tx_rst;
    logic [7:0]  lc, fc, ef;
    int          n_pop = 0, n_frst = 0;
    logic [15:0] dvs;
    logic [11:0] ent;
    logic [15:0] divs[3] = '{16'h0001, 16'h0003, 16'h0101};
    int          miscompares = 0, total_checks = 0, seed = 41, n_push = 0, cycles = 0, g;
    ucr_regs u_dut (.i_clk_sys(clk_sys), .i_resetn(resetn), .i_addr(addr), .i_wr(wr), .i_rd(rd),
        .i_wdata(wdata), .o_rdata(rdata), .i_rx_data(rx_data), .i_tx_level(tx_lvl), .i_rx_level(rx_lvl),
        .i_int_status(ist), .i_line_status(ls), .i_modem_status(ms), .i_stop_det(stop_det),
        .i_resume_det(resume_det), .o_rx_pop(pop), .o_tx_push(tx_push), .o_tx_data(tx_data), .o_isr_read(),
        .o_lsr_read(), .o_msr_read(), .o_rx_fifo_reset(rx_rst), .o_tx_fifo_reset(tx_rst), .o_baud_tick(tick),
        .o_divisor(dvs), .o_int_enable(int_enable), .o_fifo_control(fifo_control), .o_line_control(lc), .o_modem_control(),
        .o_gp_output_loop(gp), .o_feature_control(fc), .o_enh_function(ef), .o_tx_trigger(txt),
        .o_rx_trigger(rxt), .o_stop_char_1(st1), .o_stop_char_2(st2), .o_resume_char_1(rs1),
        .o_resume_char_2(rs2), .o_turnaround_delay(dly), .o_flow_flags());
    ucr_host_model u_host (.i_clk_sys(clk_sys), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
    // Clock at 40 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Gives the channel side fresh random status, levels and receive data.
    task automatic shuffle();
        @(posedge clk_sys);
        rx_data <= 8'($random(seed));
        tx_lvl  <= 8'($random(seed));
        rx_lvl  <= 8'($random(seed));
        ls      <= 8'($random(seed));
        ms      <= 8'($random(seed));
        ist     <= 6'($random(seed));
        #1;
    endtask
    // One-cycle detect pulses: bit 0 stop, bit 1 resume.
    task automatic pulse(input logic [1:0] f);
        @(posedge clk_sys);
        stop_det   <= f[0];
        resume_det <= f[1];
        @(posedge clk_sys);
        stop_det   <= 1'b0;
        resume_det <= 1'b0;
    endtask
    // Cycles from one baud tick to the next, bounded.
    task automatic tick_gap(output int n);
        int k;
        k = 0;
        while (tick !== 1'b1 && k < 600) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 600);
    endtask
    // Watcher: a read answers one edge later; compare it with the oldest note.
    always @(posedge clk_sys) rd_seen <= rd;
    always @(negedge clk_sys) begin
        if (rd_seen === 1'b1) begin
            if (u_host.exp_q.size() == 0) chk("read queue", 16'h0001, 16'h0000);
            else begin
                ent = u_host.exp_q.pop_front();
                chk($sformatf("rdata offset %h", ent[11:8]), 16'(ent[7:0]), 16'(rdata));
            end
        end
    end
    // Counts transmit pushes and cuts a hang short.
    always @(posedge clk_sys) begin
        if (tx_push === 1'b1) n_push <= n_push + 1;
        if (pop === 1'b1) n_pop <= n_pop + 1;
        if (rx_rst === 1'b1 && tx_rst === 1'b1) n_frst <= n_frst + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        resetn = 1'b0;
        {stop_det, resume_det, rx_data, tx_lvl, rx_lvl, ls, ms, ist, rd_seen} = '0;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        foreach (divs[i]) begin
            u_host.set_div(divs[i]);
            u_host.idle();
            chk("divisor", divs[i], dvs);
            tick_gap(g);
            chk("tick gap", divs[i], 16'(g));
        end
        u_host.wr(UCR_OFF_LCR, 8'h80);
        u_host.rd(UCR_OFF_DATA, 8'h01);
        u_host.rd(UCR_OFF_IER, 8'h01);
        u_host.wr(UCR_OFF_LCR, 8'h03);
        u_host.wr(UCR_OFF_IER, 8'hff);
        u_host.rd(UCR_OFF_LCR, 8'h03);
        u_host.idle();
        chk("divisor kept", 16'h0101, dvs);
        chk("int enable", 16'h000f, 16'(int_enable));
        chk("line control", 16'h0003, 16'(lc));
        $display("done: divisor");
        shuffle();
        d = 8'($random(seed));
        u_host.rd(UCR_OFF_DATA, rx_data);
        u_host.wr(UCR_OFF_DATA, d);
        u_host.idle();
        chk("tx data", 16'(d), 16'(tx_data));
        chk("tx pushes", 16'h0001, 16'(n_push));
        chk("rx pops", 16'h0001, 16'(n_pop));
        $display("done: holding");
        for (int e = 0; e < 2; e++) begin
            shuffle();
            u_host.wr(UCR_OFF_EFR, e ? 8'h10 : 8'h00);
            u_host.wr(UCR_OFF_IER, 8'hff);
            u_host.wr(UCR_OFF_MCR, 8'hff);
            u_host.wr(UCR_OFF_ISR, 8'h31);
            u_host.rd(UCR_OFF_IER, e ? 8'hef : 8'h0f);
            u_host.rd(UCR_OFF_MCR, e ? 8'hff : 8'h1b);
            u_host.rd(UCR_OFF_ISR, {2'b11, e ? ist : (ist & 6'h0f)});
            u_host.idle();
            chk("fifo control", e ? 16'h0031 : 16'h0001, 16'(fifo_control));
            chk("loop outputs", e ? 16'h0003 : 16'h0002, 16'(gp));
        end
        u_host.wr(UCR_OFF_MCR, 8'h0c);
        u_host.wr(UCR_OFF_ISR, 8'h06);
        u_host.idle();
        chk("loop outputs off", 16'h0000, 16'(gp));
        chk("fifo resets", 16'h0001, 16'(n_frst));
        $display("done: gating");
        shuffle();
        u_host.rd(UCR_OFF_TXLVL, tx_lvl);
        u_host.rd(UCR_OFF_RXLVL, rx_lvl);
        u_host.wr(UCR_OFF_TXLVL, 8'h5a);
        u_host.wr(UCR_OFF_RXLVL, 8'ha6);
        u_host.wr(UCR_OFF_XCHAR, 8'h13);
        u_host.wr(UCR_OFF_STOP2, 8'h93);
        u_host.wr(UCR_OFF_RES1, 8'h11);
        u_host.wr(UCR_OFF_RES2, 8'h91);
        u_host.wr(UCR_OFF_MSR, 8'hc5);
        u_host.wr(UCR_OFF_FEAT, 8'h2a);
        u_host.wr(UCR_OFF_LSR, ~ls);
        u_host.rd(UCR_OFF_LSR, ls);
        u_host.rd(UCR_OFF_MSR, ms);
        for (int a = 13; a < 16; a++) u_host.rd(4'(a), 8'h00);
        u_host.idle();
        chk("tx trigger", 16'h005a, 16'(txt));
        chk("rx trigger", 16'h00a6, 16'(rxt));
        chk("stop char 1", 16'h0013, 16'(st1));
        chk("stop char 2", 16'h0093, 16'(st2));
        chk("resume char 1", 16'h0011, 16'(rs1));
        chk("resume char 2", 16'h0091, 16'(rs2));
        chk("turnaround", 16'h000c, 16'(dly));
        chk("feature control", 16'h002a, 16'(fc));
        chk("enhanced function", 16'h0010, 16'(ef));
        $display("done: enhanced registers");
        for (int f = 1; f < 4; f++) begin
            pulse(2'(f));
            u_host.rd(UCR_OFF_XCHAR, 8'(f));
            u_host.rd(UCR_OFF_XCHAR, 8'h00);
            u_host.idle();
        end
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            u_host.wr(UCR_OFF_SPR, d);
            u_host.rd(UCR_OFF_SPR, d);
        end
        u_host.idle();
        $display("done: flags and scratch");
        stop_test();
    end
endmodule
